// file: inc/sbx_pkg.sv
package sbx_pkg;

    // ========================================================
    // opcodes
    localparam logic [7:0] OP_NO_PRE = 8'h00;
    localparam logic [7:0] OP_PRE_SP = 8'h9e;
    localparam logic [7:0] OP_ASR_DIR = 8'h37;
    localparam logic [7:0] OP_ASR_ACC = 8'h47;
    localparam logic [7:0] OP_ASR_IDX = 8'h57;
    localparam logic [7:0] OP_ASR_IX1 = 8'h67;
    localparam logic [7:0] OP_ASR_IX = 8'h77;
    localparam logic [7:0] OP_BR_CC = 8'h24;
    localparam logic [7:0] OP_BR_CS = 8'h25;
    localparam logic [7:0] OP_BR_EQ = 8'h27;
    localparam logic [7:0] OP_BR_HCC = 8'h28;
    localparam logic [7:0] OP_BR_GE = 8'h90;
    localparam logic [7:0] OP_BR_GT = 8'h92;
    localparam logic [3:0] OP_CLEAR_BIT_IN_MEMORY_HI = 4'h1;

    // ========================================================
    // cycle counts and instruction lengths
    localparam logic [2:0] CYC_ASR_DIR = 3'd4;
    localparam logic [2:0] CYC_ASR_INH = 3'd1;
    localparam logic [2:0] CYC_ASR_IX1 = 3'd4;
    localparam logic [2:0] CYC_ASR_IX = 3'd3;
    localparam logic [2:0] CYC_ASR_SP1 = 3'd5;
    localparam logic [2:0] CYC_BRANCH = 3'd3;
    localparam logic [2:0] CYC_CLEAR_BIT_IN_MEMORY = 3'd4;
    localparam logic [1:0] LEN_1 = 2'd1;
    localparam logic [1:0] LEN_2 = 2'd2;
    localparam logic [1:0] LEN_3 = 2'd3;

    // ========================================================
    // condition code bit positions and reset values
    localparam int CCR_V = 7;
    localparam int CCR_H = 4;
    localparam int CCR_I = 3;
    localparam int CCR_N = 2;
    localparam int CCR_Z = 1;
    localparam int CCR_C = 0;
    localparam logic [7:0] CCR_ONES = 8'h60;
    localparam logic [7:0] RST_CCR = 8'h68;
    localparam logic [15:0] RST_SP = 16'h00ff;
    localparam logic [15:0] RST_PC = 16'h0000;
    localparam logic [7:0] RST_BYTE = 8'h00;

    // ========================================================
    // register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_INSTR = 8'h08;
    localparam logic [7:0] REG_ACC = 8'h0c;
    localparam logic [7:0] REG_IDX = 8'h10;
    localparam logic [7:0] REG_PC = 8'h14;
    localparam logic [7:0] REG_SP = 8'h18;
    localparam logic [7:0] REG_CCR = 8'h1c;
    localparam logic [7:0] REG_MADDR = 8'h20;
    localparam logic [7:0] REG_MDATA = 8'h24;
    localparam int CTRL_GO = 0;
    localparam int CTRL_ERR_CLR = 1;

    // ========================================================
    // types
    typedef enum logic [2:0] {
        K_NONE, K_ASR_A, K_ASR_X, K_ASR_M, K_BRANCH, K_CLEAR_BIT_IN_MEMORY
    } sbx_kind_type;
    typedef enum logic [2:0] {M_NONE, M_DIR, M_IX1, M_IX, M_SP1} sbx_mode_type;
    typedef enum logic [2:0] {C_CC, C_CS, C_EQ, C_GE, C_GT, C_HCC} sbx_cond_type;
    typedef struct packed {
        sbx_kind_type kind;
        sbx_mode_type mode;
        logic [2:0] cycles;
        logic [1:0] len;
        sbx_cond_type cond;
    } sbx_dec_type;

    // ========================================================
    // opcode decode
    function automatic sbx_dec_type sbx_decode(input logic [7:0] pre,
                                               input logic [7:0] op);
        sbx_dec_type d;
        d = '{K_NONE, M_NONE, 3'd0, 2'd0, C_CC};
        if (pre == OP_PRE_SP) begin
            if (op == OP_ASR_IX1) d = '{K_ASR_M, M_SP1, CYC_ASR_SP1, LEN_3, C_CC};
        end else if (pre == OP_NO_PRE) begin
            case (op)
                OP_ASR_DIR: d = '{K_ASR_M, M_DIR, CYC_ASR_DIR, LEN_2, C_CC};
                OP_ASR_ACC: d = '{K_ASR_A, M_NONE, CYC_ASR_INH, LEN_1, C_CC};
                OP_ASR_IDX: d = '{K_ASR_X, M_NONE, CYC_ASR_INH, LEN_1, C_CC};
                OP_ASR_IX1: d = '{K_ASR_M, M_IX1, CYC_ASR_IX1, LEN_2, C_CC};
                OP_ASR_IX: d = '{K_ASR_M, M_IX, CYC_ASR_IX, LEN_1, C_CC};
                OP_BR_CC: d = '{K_BRANCH, M_NONE, CYC_BRANCH, LEN_2, C_CC};
                OP_BR_CS: d = '{K_BRANCH, M_NONE, CYC_BRANCH, LEN_2, C_CS};
                OP_BR_EQ: d = '{K_BRANCH, M_NONE, CYC_BRANCH, LEN_2, C_EQ};
                OP_BR_HCC: d = '{K_BRANCH, M_NONE, CYC_BRANCH, LEN_2, C_HCC};
                OP_BR_GE: d = '{K_BRANCH, M_NONE, CYC_BRANCH, LEN_2, C_GE};
                OP_BR_GT: d = '{K_BRANCH, M_NONE, CYC_BRANCH, LEN_2, C_GT};
                default: begin
                    if (op[7:4] == OP_CLEAR_BIT_IN_MEMORY_HI && op[0])
                        d = '{K_CLEAR_BIT_IN_MEMORY, M_DIR, CYC_CLEAR_BIT_IN_MEMORY, LEN_2, C_CC};
                end
            endcase
        end
        return d;
    endfunction

    // branch condition test
    function automatic logic sbx_taken(input sbx_cond_type c,
                                       input logic [7:0] f);
        case (c)
            C_CC: return !f[CCR_C];
            C_CS: return f[CCR_C];
            C_EQ: return f[CCR_Z];
            C_GE: return !(f[CCR_N] ^ f[CCR_V]);
            C_GT: return !(f[CCR_Z] | (f[CCR_N] ^ f[CCR_V]));
            C_HCC: return !f[CCR_H];
            default: return 1'b0;
        endcase
    endfunction

endpackage

// file: hw/sbx_asr_alu.sv
`timescale 1ns/100ps
module sbx_asr_alu
    import sbx_pkg::*;
(
    input wire logic [7:0] operand,
    input wire logic [7:0] ccr_in,
    output logic [7:0] result,
    output logic [7:0] ccr_out
);
    // ========================================================
    // shift right keeping the sign bit
    always_comb begin
        result = {operand[7], operand[7:1]};
        ccr_out = ccr_in;
        ccr_out[CCR_C] = operand[0];
        ccr_out[CCR_N] = result[7];
        ccr_out[CCR_Z] = (result == 8'h00);
        ccr_out[CCR_V] = result[7] ^ operand[0];
    end
endmodule // sbx_asr_alu

// file: hw/sbx_dp_mem.sv
`timescale 1ns/100ps
module sbx_dp_mem #(
    parameter int AW = 8,
    parameter int DW = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [DW-1:0] wdata,
    input wire logic [AW-1:0] raddr,
    output logic [DW-1:0] rdata_ff
);
    // ========================================================
    // storage with registered read
    generate
        if (AW < 1 || AW > 16 || DW < 1) begin : g_bad
            $error("sbx_dp_mem: unsupported geometry");
        end
    endgenerate

    logic [DW-1:0] mem [2**AW];

    always_ff @(posedge clk) begin
        if (ce && we) begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_ff <= '0;
        end else if (ce) begin
            rdata_ff <= mem[raddr];
        end
    end
endmodule // sbx_dp_mem

// file: hw/sbx_exec_top.sv
// Contract
// - an arithmetic right shift loads carry from operand bit 0 before it.
// - the shift sets overflow to result sign xor new carry.
// - the shift copies result bit 7 to N, sets Z on a zero result, keeps H and I.
// - shift opcodes 37/47/57/67/77/9E67 take 4/1/1/4/3/5 cycles.
// - opcode 24 branches to pc+2+rel when carry is clear, in 3 cycles.
// - opcode 25 branches when carry is set, in 3 cycles.
// - opcode 27 branches when zero is set, in 3 cycles.
// - opcode 90 branches when N xor V is zero, in 3 cycles.
// - opcode 92 branches when Z or (N xor V) is zero, in 3 cycles.
// - opcode 28 branches when half carry is clear, in 3 cycles.
// - odd opcodes 11 to 1F clear only bit n of a direct location, 4 cycles.
// - the bit clear reads the whole byte, alters one bit, writes it back.
//
// The placing of the registers and register access over AHB-Lite were chosen for this implementation.
`timescale 1ns/100ps
module sbx_exec_top
    import sbx_pkg::*;
#(
    parameter int MEM_AW = 8
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp
);
    generate
        if (MEM_AW != 8) begin : g_bad
            $error("sbx_exec_top: direct page must be 8 address bits");
        end
    endgenerate

    typedef enum logic {S_IDLE, S_RUN} sbx_state_type;

    // ========================================================
    // declarations
    sbx_state_type state_ff;
    sbx_dec_type dec_ff, dec_now;
    logic [7:0] addr_ff;
    logic addr_ok_ff, wr_pend_ff, rd_pend_ff;
    logic [31:0] hrdata_ff, rd_val;
    logic hreadyout_ff, hresp_ff;
    logic [7:0] acc_ff, idx_ff, ccr_ff, mem_addr_ff;
    logic [15:0] pc_ff, sp_ff;
    logic [7:0] op_ff, pre_ff, opnd_ff, ea_ff, nxt_ea;
    logic [2:0] cnt_ff, bit_ff;
    logic err_ff, taken_ff;
    logic bus_wr, go, fin, busy;
    logic [7:0] mem_rdata, alu_in, alu_res, alu_ccr;
    logic mem_we;
    logic [7:0] mem_wdata, mem_waddr, mem_raddr;
    logic [15:0] pc_next;

    assign hrdata = hrdata_ff;
    assign hreadyout = hreadyout_ff;
    assign hresp = hresp_ff;
    assign busy = (state_ff == S_RUN);
    assign bus_wr = wr_pend_ff && addr_ok_ff && !busy;
    assign dec_now = sbx_decode(pre_ff, op_ff);
    assign go = bus_wr && addr_ff == REG_CTRL && hwdata[CTRL_GO];
    assign fin = busy && cnt_ff == 3'd0;

    // ========================================================
    // ahb-lite slave: writes zero wait, reads one wait state
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            addr_ff <= 8'h00;
            addr_ok_ff <= 1'b0;
            wr_pend_ff <= 1'b0;
            rd_pend_ff <= 1'b0;
            hreadyout_ff <= 1'b1;
            hrdata_ff <= 32'h0000_0000;
            hresp_ff <= 1'b0;
        end else if (ce) begin
            wr_pend_ff <= 1'b0;
            if (rd_pend_ff) begin
                rd_pend_ff <= 1'b0;
                hrdata_ff <= rd_val;
                hreadyout_ff <= 1'b1;
            end else if (hsel && hready && htrans[1]) begin
                addr_ff <= haddr[7:0];
                addr_ok_ff <= (haddr[31:8] == 24'h00_0000);
                wr_pend_ff <= hwrite;
                rd_pend_ff <= !hwrite;
                hreadyout_ff <= hwrite;
            end
        end
    end

    always_comb begin
        rd_val = 32'h0000_0000;
        if (addr_ok_ff) begin
            case (addr_ff)
                REG_STATUS: rd_val = {29'h0, taken_ff, err_ff, busy};
                REG_INSTR: rd_val = {8'h00, opnd_ff, pre_ff, op_ff};
                REG_ACC: rd_val = {24'h00_0000, acc_ff};
                REG_IDX: rd_val = {24'h00_0000, idx_ff};
                REG_PC: rd_val = {16'h0000, pc_ff};
                REG_SP: rd_val = {16'h0000, sp_ff};
                REG_CCR: rd_val = {24'h00_0000, ccr_ff};
                REG_MADDR: rd_val = {24'h00_0000, mem_addr_ff};
                REG_MDATA: rd_val = {24'h00_0000, mem_rdata};
                default: rd_val = 32'h0000_0000;
            endcase
        end
    end

    // ========================================================
    // instruction and memory pointer registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            op_ff <= RST_BYTE;
            pre_ff <= RST_BYTE;
            opnd_ff <= RST_BYTE;
            mem_addr_ff <= RST_BYTE;
        end else if (ce && bus_wr) begin
            if (addr_ff == REG_INSTR) begin
                op_ff <= hwdata[7:0];
                pre_ff <= hwdata[15:8];
                opnd_ff <= hwdata[23:16];
            end
            if (addr_ff == REG_MADDR) mem_addr_ff <= hwdata[7:0];
        end
    end

    // ========================================================
    // sequencer: busy for exactly the documented cycle count
    always_comb begin
        case (dec_now.mode)
            M_DIR: nxt_ea = opnd_ff;
            M_IX1: nxt_ea = idx_ff + opnd_ff;
            M_IX: nxt_ea = idx_ff;
            M_SP1: nxt_ea = sp_ff[7:0] + opnd_ff;
            default: nxt_ea = opnd_ff;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_ff <= S_IDLE;
            dec_ff <= '{K_NONE, M_NONE, 3'd0, 2'd0, C_CC};
            cnt_ff <= 3'd0;
            ea_ff <= 8'h00;
            bit_ff <= 3'd0;
        end else if (ce) begin
            case (state_ff)
                S_IDLE: begin
                    if (go && dec_now.kind != K_NONE) begin
                        state_ff <= S_RUN;
                        dec_ff <= dec_now;
                        cnt_ff <= dec_now.cycles - 3'd1;
                        ea_ff <= nxt_ea;
                        bit_ff <= op_ff[3:1];
                    end
                end
                S_RUN: begin
                    if (cnt_ff == 3'd0) state_ff <= S_IDLE;
                    else cnt_ff <= cnt_ff - 3'd1;
                end
                default: state_ff <= S_IDLE;
            endcase
        end
    end

    // error set wins over software clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            err_ff <= 1'b0;
        end else if (ce) begin
            if (go && !busy && dec_now.kind == K_NONE) err_ff <= 1'b1;
            else if (bus_wr && addr_ff == REG_CTRL && hwdata[CTRL_ERR_CLR])
                err_ff <= 1'b0;
        end
    end

    // ========================================================
    // datapath
    assign alu_in = (dec_ff.kind == K_ASR_A) ? acc_ff :
                    (dec_ff.kind == K_ASR_X) ? idx_ff : mem_rdata;

    sbx_asr_alu u_alu (
        .operand(alu_in),
        .ccr_in(ccr_ff),
        .result(alu_res),
        .ccr_out(alu_ccr)
    );

    assign pc_next = (dec_ff.kind == K_BRANCH && sbx_taken(dec_ff.cond, ccr_ff))
        ? pc_ff + 16'd2 + {{8{opnd_ff[7]}}, opnd_ff}
        : pc_ff + {14'h0000, dec_ff.len};

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pc_ff <= RST_PC;
            taken_ff <= 1'b0;
        end else if (ce) begin
            if (fin) begin
                pc_ff <= pc_next;
                taken_ff <= dec_ff.kind == K_BRANCH
                            && sbx_taken(dec_ff.cond, ccr_ff);
            end else if (bus_wr && addr_ff == REG_PC) begin
                pc_ff <= hwdata[15:0];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ccr_ff <= RST_CCR;
        end else if (ce) begin
            if (fin && (dec_ff.kind == K_ASR_A || dec_ff.kind == K_ASR_X
                        || dec_ff.kind == K_ASR_M)) begin
                ccr_ff <= alu_ccr;
            end else if (bus_wr && addr_ff == REG_CCR) begin
                ccr_ff <= hwdata[7:0] | CCR_ONES;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            acc_ff <= RST_BYTE;
        end else if (ce) begin
            if (fin && dec_ff.kind == K_ASR_A) acc_ff <= alu_res;
            else if (bus_wr && addr_ff == REG_ACC) acc_ff <= hwdata[7:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            idx_ff <= RST_BYTE;
        end else if (ce) begin
            if (fin && dec_ff.kind == K_ASR_X) idx_ff <= alu_res;
            else if (bus_wr && addr_ff == REG_IDX) idx_ff <= hwdata[7:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sp_ff <= RST_SP;
        end else if (ce && bus_wr && addr_ff == REG_SP) begin
            sp_ff <= hwdata[15:0];
        end
    end

    // ========================================================
    // direct page memory: read at start, whole byte written at end
    assign mem_raddr = busy ? ea_ff : mem_addr_ff;
    assign mem_we = (fin && (dec_ff.kind == K_ASR_M || dec_ff.kind == K_CLEAR_BIT_IN_MEMORY))
                    || (bus_wr && addr_ff == REG_MDATA);
    assign mem_waddr = busy ? ea_ff : mem_addr_ff;
    assign mem_wdata = !busy ? hwdata[7:0] :
                       (dec_ff.kind == K_CLEAR_BIT_IN_MEMORY)
                       ? (mem_rdata & ~(8'h01 << bit_ff))
                       : alu_res;

    sbx_dp_mem #(
        .AW(MEM_AW),
        .DW(8)
    ) u_mem (
        .clk(hclk),
        .rst_n(hresetn),
        .ce(ce),
        .we(mem_we),
        .waddr(mem_waddr),
        .wdata(mem_wdata),
        .raddr(mem_raddr),
        .rdata_ff(mem_rdata)
    );

    // ========================================================
    // checks
    logic start;
    assign start = go && !busy && dec_now.kind != K_NONE;

    property p_asr_c;
        @(posedge hclk) disable iff (!hresetn)
        (ce && fin && dec_ff.kind == K_ASR_A)
        |=> ccr_ff[CCR_C] == $past(acc_ff[0]);
    endproperty
    a_asr_c: assert property (p_asr_c) else $error("carry not from bit 0");

    property p_asr_v;
        @(posedge hclk) disable iff (!hresetn)
        (ce && fin && dec_ff.kind != K_BRANCH && dec_ff.kind != K_CLEAR_BIT_IN_MEMORY)
        |=> ccr_ff[CCR_V] == (ccr_ff[CCR_N] ^ ccr_ff[CCR_C]);
    endproperty
    a_asr_v: assert property (p_asr_v) else $error("overflow wrong");

    property p_asr_nz;
        @(posedge hclk) disable iff (!hresetn)
        (ce && fin && dec_ff.kind == K_ASR_X)
        |=> idx_ff[7] == $past(idx_ff[7]) && ccr_ff[CCR_N] == idx_ff[7]
            && ccr_ff[CCR_Z] == (idx_ff == 8'h00)
            && ccr_ff[CCR_H] == $past(ccr_ff[CCR_H])
            && ccr_ff[CCR_I] == $past(ccr_ff[CCR_I]);
    endproperty
    a_asr_nz: assert property (p_asr_nz) else $error("shift N/Z/H/I wrong");

    property p_dir_cyc;
        @(posedge hclk) disable iff (!hresetn || !ce)
        (start && pre_ff == OP_NO_PRE && op_ff == OP_ASR_DIR)
        |=> busy [*4] ##1 !busy;
    endproperty
    a_dir_cyc: assert property (p_dir_cyc) else $error("dir cycles");

    property p_sp1_cyc;
        @(posedge hclk) disable iff (!hresetn || !ce)
        (start && pre_ff == OP_PRE_SP) |=> busy [*5] ##1 !busy;
    endproperty
    a_sp1_cyc: assert property (p_sp1_cyc) else $error("sp1 cycles");

    property p_br_cyc;
        @(posedge hclk) disable iff (!hresetn || !ce)
        (start && dec_now.kind == K_BRANCH) |=> busy [*3] ##1 !busy;
    endproperty
    a_br_cyc: assert property (p_br_cyc) else $error("branch cycles");

    property p_br_pc;
        @(posedge hclk) disable iff (!hresetn)
        (ce && fin && dec_ff.kind == K_BRANCH)
        |=> pc_ff == $past(pc_ff) + 16'd2
            + (taken_ff ? {{8{opnd_ff[7]}}, opnd_ff} : 16'd0);
    endproperty
    a_br_pc: assert property (p_br_pc) else $error("branch target");

    property p_gt_cond;
        @(posedge hclk) disable iff (!hresetn)
        (ce && fin && dec_ff.cond == C_GT && dec_ff.kind == K_BRANCH)
        |=> taken_ff == !($past(ccr_ff[CCR_Z])
            | ($past(ccr_ff[CCR_N]) ^ $past(ccr_ff[CCR_V])));
    endproperty
    a_gt_cond: assert property (p_gt_cond) else $error("gt test");

    property p_clear_bit_in_memory;
        @(posedge hclk) disable iff (!hresetn)
        (ce && fin && dec_ff.kind == K_CLEAR_BIT_IN_MEMORY)
        |-> mem_we && mem_wdata[bit_ff] == 1'b0
            && (mem_wdata | (8'h01 << bit_ff)) == (mem_rdata | (8'h01 << bit_ff));
    endproperty
    a_clear_bit_in_memory: assert property (p_clear_bit_in_memory) else $error("bit clear");

    property p_ccr_keep;
        @(posedge hclk) disable iff (!hresetn)
        (ce && fin && (dec_ff.kind == K_BRANCH || dec_ff.kind == K_CLEAR_BIT_IN_MEMORY))
        |=> $stable(ccr_ff);
    endproperty
    a_ccr_keep: assert property (p_ccr_keep) else $error("flags moved");

    c_taken: cover property (@(posedge hclk) fin && dec_ff.kind == K_BRANCH
                             && sbx_taken(dec_ff.cond, ccr_ff));
    c_clear_bit_in_memory: cover property (@(posedge hclk) fin && dec_ff.kind == K_CLEAR_BIT_IN_MEMORY);
    c_asr_m: cover property (@(posedge hclk) fin && dec_ff.mode == M_SP1);
endmodule // sbx_exec_top

// file: verification/sbx_exec_top_tb.sv
`timescale 1ns/100ps
module sbx_exec_top_tb;
    import sbx_pkg::*;
    logic hclk, hresetn, ce, hsel, hwrite, hready, hreadyout, hresp, t;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, r, seed;
    logic [7:0] v, f, x, d, ea;
    logic [15:0] pc, e;
    logic [7:0] ops [6] = '{OP_ASR_ACC, OP_ASR_IDX, OP_ASR_DIR, OP_ASR_IX1,
        OP_ASR_IX, OP_ASR_IX1};
    logic [7:0] bops [6] = '{OP_BR_CC, OP_BR_CS, OP_BR_EQ, OP_BR_HCC,
        OP_BR_GE, OP_BR_GT};
    int lens [6] = '{1, 1, 2, 2, 1, 3};
    int bad_count, cmp_count;

    sbx_exec_top u_dut (.hclk(hclk), .hresetn(hresetn), .ce(ce),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp));
    assign hready = hreadyout;

    initial begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end

    // ========================================================
    // helpers
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // returns {flags, result} of a signed shift right
    function automatic logic [15:0] shr_model(input logic [7:0] a,
                                              input logic [7:0] c);
        logic [7:0] q;
        logic [7:0] g;
        q = {a[7], a[7:1]};
        g = c;
        g[0] = a[0];
        g[2] = q[7];
        g[1] = (q == 8'h00);
        g[7] = q[7] ^ a[0];
        return {g, q};
    endfunction

    task automatic report_and_stop();
        $display("counts: %0d compares, %0d mismatches", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] s, input logic [31:0] xp);
        cmp_count++;
        if (s !== xp) begin
            bad_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, s, xp);
        end
    endtask

    // waits for hready sampled high at a rising edge
    task automatic wt();
        int i;
        i = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1) begin
            i++;
            if (i > 50) begin
                bad_count++;
                report_and_stop();
            end
            @(posedge hclk);
        end
    endtask

    task automatic bus(input logic w, input logic [31:0] a,
                       input logic [31:0] wd);
        haddr <= a;
        hwrite <= w;
        htrans <= 2'b10;
        wt();
        htrans <= 2'b00;
        hwdata <= wd;
        wt();
        r = hrdata;
    endtask

    // loads an instruction, starts it, polls until idle; r keeps status
    task automatic run(input logic [31:0] ins);
        int i;
        bus(1'b1, 32'(REG_INSTR), ins);
        bus(1'b1, 32'(REG_CTRL), 32'h0000_0001);
        i = 0;
        r = 32'h0000_0001;
        while (r[0] !== 1'b0) begin
            bus(1'b0, 32'(REG_STATUS), 32'h0000_0000);
            i++;
            if (i > 20) begin
                bad_count++;
                report_and_stop();
            end
        end
    endtask

    task automatic setup(input logic [7:0] fl, input logic [15:0] p);
        bus(1'b1, 32'(REG_CCR), 32'(fl));
        bus(1'b1, 32'(REG_PC), 32'(p));
    endtask

    // ========================================================
    // main sequence
    initial begin
        hresetn = 1'b0;
        ce = 1'b1;
        hsel = 1'b1;
        htrans = 2'b00;
        haddr = 32'h0000_0000;
        hwrite = 1'b0;
        hsize = 3'd2;
        hwdata = 32'h0000_0000;
        seed = 32'd61;
        bad_count = 0;
        cmp_count = 0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        for (int k = 0; k < 12; k++) begin
            v = (k == 0) ? 8'h01 : 8'(rnd());
            f = 8'(rnd()) | CCR_ONES;
            x = 8'(rnd());
            d = 8'(rnd());
            pc = 16'(rnd());
            case (k % 6)
                2: ea = d;
                3: ea = x + d;
                4: ea = x;
                5: ea = RST_SP[7:0] + d;
                default: ea = 8'h00;
            endcase
            bus(1'b1, 32'(REG_ACC), 32'(v));
            bus(1'b1, 32'(REG_IDX), 32'(x));
            bus(1'b1, 32'(REG_MADDR), 32'(ea));
            bus(1'b1, 32'(REG_MDATA), 32'(v));
            setup(f, pc);
            run({8'h00, d, (k % 6 == 5) ? OP_PRE_SP : OP_NO_PRE, ops[k % 6]});
            e = shr_model((k % 6 == 1) ? x : v, f);
            bus(1'b0, (k % 6 == 0) ? 32'(REG_ACC) : (k % 6 == 1) ?
                32'(REG_IDX) : 32'(REG_MDATA), 32'h0000_0000);
            chk(r, 32'(e[7:0]));
            bus(1'b0, 32'(REG_CCR), 32'h0000_0000);
            chk(r, 32'(e[15:8]));
            bus(1'b0, 32'(REG_PC), 32'h0000_0000);
            chk(r, 32'(pc + 16'(lens[k % 6])));
        end
        $display("shift test done");
        for (int k = 0; k < 36; k++) begin
            f = 8'(rnd()) | CCR_ONES;
            d = 8'(rnd());
            pc = 16'(rnd());
            setup(f, pc);
            run({8'h00, d, OP_NO_PRE, bops[k % 6]});
            case (k % 6)
                0: t = !f[0];
                1: t = f[0];
                2: t = f[1];
                3: t = !f[4];
                4: t = !(f[2] ^ f[7]);
                default: t = !(f[1] | (f[2] ^ f[7]));
            endcase
            chk(32'(r[2]), 32'(t));
            e = pc + 16'h0002 + (t ? {{8{d[7]}}, d} : 16'h0000);
            bus(1'b0, 32'(REG_PC), 32'h0000_0000);
            chk(r, 32'(e));
            bus(1'b0, 32'(REG_CCR), 32'h0000_0000);
            chk(r, 32'(f));
        end
        $display("branch test done");
        for (int n = 0; n < 8; n++) begin
            v = 8'(rnd());
            ea = 8'(rnd());
            f = 8'(rnd()) | CCR_ONES;
            pc = 16'(rnd());
            setup(f, pc);
            bus(1'b1, 32'(REG_MADDR), 32'(ea));
            bus(1'b1, 32'(REG_MDATA), 32'(v));
            run({8'h00, ea, OP_NO_PRE, 8'(8'h11 + 2 * n)});
            bus(1'b0, 32'(REG_MDATA), 32'h0000_0000);
            chk(r, 32'(v & ~(8'h01 << n)));
            bus(1'b0, 32'(REG_CCR), 32'h0000_0000);
            chk(r, 32'(f));
            bus(1'b0, 32'(REG_PC), 32'h0000_0000);
            chk(r, 32'(pc + 16'h0002));
        end
        $display("bit clear test done");
        setup(CCR_ONES, 16'h1234);
        run({8'h00, 8'h00, 8'h55, OP_ASR_ACC});
        chk(32'(r[1]), 32'h0000_0001);
        bus(1'b0, 32'(REG_PC), 32'h0000_0000);
        chk(r, 32'h0000_1234);
        bus(1'b1, 32'(REG_CTRL), 32'h0000_0002);
        bus(1'b0, 32'(REG_STATUS), 32'h0000_0000);
        chk(32'(r[1]), 32'h0000_0000);
        bus(1'b0, 32'h0000_0100, 32'h0000_0000);
        chk(r, 32'h0000_0000);
        chk(32'(hresp), 32'h0000_0000);
        $display("error and map test done");
        report_and_stop();
    end
endmodule // sbx_exec_top_tb
